/* rtl/bss_defs.svh */
// constants for the buck supervisor sequencer: timing, register map, fields
// assumes a single 250 MHz clock and an AXI4-Lite register bus
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

`define BSS_CLK_MHZ         250
// least times in ns, rounded up to whole cycles
`define BSS_CYC(ns)         (((ns) * `BSS_CLK_MHZ + 999) / 1000)
`define BSS_PG_DEGLITCH_NS  34000
`define BSS_START_WAIT_NS   200000
`define BSS_R2D_CONV_NS     20000

// byte addresses of the register words
`define BSS_CTRL_ADDR       8'h00
`define BSS_STAT_ADDR       8'h04
`define BSS_LIVE_ADDR       8'h08

// control word fields and reset value
`define BSS_CTRL_FFM_BIT    0
`define BSS_CTRL_RST        1'h0
// sticky status fields and reset value
`define BSS_ST_LOCK_BIT     0
`define BSS_ST_WARN_BIT     1
`define BSS_ST_HOT_BIT      2
`define BSS_ST_RSVD_BIT     3
`define BSS_ST_W            4
`define BSS_STAT_RST        4'h0

// positions of the synchronised pin inputs
`define BSS_IN_ON           0
`define BSS_IN_INPUT_UNDERVOLTAGE_LOCKOUT         1
`define BSS_IN_POR          2
`define BSS_IN_HOT          3
`define BSS_IN_WARM         4
`define BSS_IN_WIN          5
`define BSS_IN_LVL          6
`define BSS_IN_RAMP         7
`define BSS_IN_W            8

// regulation reference in mV
`define BSS_MV_W            11
`define BSS_ADJ_REF_MV      11'h258

`define BSS_RESP_OKAY       2'h0
`define BSS_RESP_SLVERR     2'h2

`endif

/* rtl/bss_pkg.sv */
// types shared by the buck supervisor sequencer files
// assumes nothing beyond the constants header
package bss_pkg;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      BSS_OFF   = 6'h01,
      BSS_LOCK  = 6'h02,
      BSS_HOT   = 6'h04,
      BSS_WAIT  = 6'h08,
      BSS_SOFT  = 6'h10,
      BSS_RUN   = 6'h20
   } bss_state_e;

   typedef logic [3:0] bss_code_t;

endpackage : bss_pkg

/* rtl/bss_deglitch.sv */
// symmetric deglitch filter for one level signal
// assumes input already on the clk domain
module bss_deglitch #(
   parameter int   CYC     = 8500,
   parameter logic RST_VAL = 1'b1
) (
   input  logic clk,    // system clock
   input  logic rst,    // async reset, active high
   input  logic lvlIn,  // raw level
   output logic lvlOut  // filtered level
);

   localparam int CW = $clog2(CYC + 1);

   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          out_r, out_nxt;

   // output follows only after the new level held CYC cycles
   always_comb begin
      cnt_nxt = '0;
      out_nxt = out_r;
      if (lvlIn != out_r) begin
         if (cnt_r == CW'(CYC - 1)) begin
            out_nxt = lvlIn;
         end else begin
            cnt_nxt = cnt_r + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         out_r <= RST_VAL;
      end else begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end

   assign lvlOut = out_r;

endmodule : bss_deglitch

/* rtl/bss_top.sv */
// supervisor and start-up sequencer of a step-down converter
// assumes analogue comparators, strap ADC and ramp outside; AXI4-Lite regs
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`include "bss_defs.svh"

module bss_top #(
   parameter int PG_CYC   = `BSS_CYC(`BSS_PG_DEGLITCH_NS),
   parameter int WAIT_CYC = `BSS_CYC(`BSS_START_WAIT_NS),
   parameter int R2D_CYC  = `BSS_CYC(`BSS_R2D_CONV_NS),
   parameter int AW       = 8
) (
   input  logic                 clk,            // 250 MHz clock
   input  logic                 rst,            // async reset, high
   input  logic                 turnOnPin,      // turn_on_input pin
   input  logic                 vinLockout,     // input below lockout
   input  logic                 vinBelowPor,    // input below 1.8V
   input  logic                 overheatShut,   // over shutdown limit
   input  logic                 overheatWarn,   // over warning limit
   input  logic                 outInWindow,    // output in 0.9..1.1
   input  logic                 levelSelIn,     // level_select_pin level
   input  logic                 rampDone,       // soft-start ramp ended
   input  bss_pkg::bss_code_t   r2dCode,        // strap ADC code
   output logic                 r2dSourceOn,    // strap current source
   output logic                 switchEnable,   // power stage may switch
   output logic                 softStartReq,   // start the ramp
   output logic                 dischargeOn,    // output discharge path
   output logic                 outOkOut,       // output_ok_flag data
   output logic                 outOkOe,        // output_ok_flag pulls low
   output logic                 adjustMode,     // divider reference used
   output logic [10:0]          refMv,          // regulation reference
   output logic                 fixedFreqMode,  // forced fixed frequency
   output bss_pkg::bss_state_e  stateOut,       // sequencer state
   input  logic [AW-1:0]        s_axi_awaddr,   // write address
   input  logic                 s_axi_awvalid,  // write address valid
   output logic                 s_axi_awready,  // write address ready
   input  logic [31:0]          s_axi_wdata,    // write data
   input  logic [3:0]           s_axi_wstrb,    // write strobes
   input  logic                 s_axi_wvalid,   // write data valid
   output logic                 s_axi_wready,   // write data ready
   output logic [1:0]           s_axi_bresp,    // write response
   output logic                 s_axi_bvalid,   // write response valid
   input  logic                 s_axi_bready,   // write response ready
   input  logic [AW-1:0]        s_axi_araddr,   // read address
   input  logic                 s_axi_arvalid,  // read address valid
   output logic                 s_axi_arready,  // read address ready
   output logic [31:0]          s_axi_rdata,    // read data
   output logic [1:0]           s_axi_rresp,    // read response
   output logic                 s_axi_rvalid,   // read data valid
   input  logic                 s_axi_rready    // read data ready
);
   import bss_pkg::*;

   localparam int TW = $clog2(WAIT_CYC + 1);

   // strap level decode: mV target, zero means adjustable
   function automatic logic [`BSS_MV_W-1:0] strapMv(bss_code_t c);
      unique case (c)
         4'he:    strapMv = 11'h640; // 1.60V
         4'hd:    strapMv = 11'h5dc; // 1.50V
         4'hc:    strapMv = 11'h546; // 1.35V
         4'hb:    strapMv = 11'h4b0; // 1.20V
         4'h9:    strapMv = 11'h3e8; // 1.00V
         4'h8:    strapMv = 11'h384; // 0.90V
         4'h7:    strapMv = 11'h352; // 0.85V
         4'h6:    strapMv = 11'h320; // 0.80V
         4'h5:    strapMv = 11'h2bc; // 0.70V
         4'h4:    strapMv = 11'h258; // 0.60V
         4'h3:    strapMv = 11'h1f4; // 0.50V
         4'h2:    strapMv = 11'h1c2; // 0.45V
         4'h1:    strapMv = 11'h190; // 0.40V
         default: strapMv = '0;      // 10k, 249k, reserved
      endcase
   endfunction : strapMv

   // pin synchroniser: three stages, change taken when 2nd and 3rd agree
   logic [`BSS_IN_W-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt, pinIn;
   assign pinIn = {rampDone, levelSelIn, outInWindow, overheatWarn,
                   overheatShut, vinBelowPor, vinLockout, turnOnPin};
   always_comb begin
      flt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         flt_r <= '0;
      end else begin
         s1_r  <= pinIn;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         flt_r <= flt_nxt;
      end
   end

   logic on, input_undervoltage_lockout, por, hot, warm, win, lvl, ramp;
   assign on   = flt_r[`BSS_IN_ON];
   assign input_undervoltage_lockout = flt_r[`BSS_IN_INPUT_UNDERVOLTAGE_LOCKOUT];
   assign por  = flt_r[`BSS_IN_POR];
   assign hot  = flt_r[`BSS_IN_HOT];
   assign warm = flt_r[`BSS_IN_WARM];
   assign win  = flt_r[`BSS_IN_WIN];
   assign lvl  = flt_r[`BSS_IN_LVL];
   assign ramp = flt_r[`BSS_IN_RAMP];

   // sequencer, start timer, strap latch and power-stage controls
   bss_state_e           st_r, st_nxt;
   logic [TW-1:0]        tmr_r, tmr_nxt;
   logic                 adj_r, adj_nxt, rsv_r, rsv_nxt;
   logic [`BSS_MV_W-1:0] ref_r, ref_nxt;
   logic                 src_r, src_nxt, sw_r, sw_nxt, ss_r, ss_nxt;
   logic                 dis_r, dis_nxt, ffm_r, ffm_nxt;
   logic [`BSS_ST_W-1:0] stat_r;
   logic                 ctrlFfm_r;

   always_comb begin
      st_nxt  = st_r;
      tmr_nxt = '0;
      adj_nxt = adj_r;
      rsv_nxt = rsv_r;
      ref_nxt = ref_r;
      // a stop overrides any state, the turn-on pin first
      if (!on || por) begin
         st_nxt = BSS_OFF;
      end else if (input_undervoltage_lockout) begin
         st_nxt = BSS_LOCK;
      end else if (hot) begin
         st_nxt = BSS_HOT;
      end else begin
         unique case (st_r)
            BSS_OFF, BSS_LOCK, BSS_HOT: begin
               st_nxt = BSS_WAIT;
            end
            BSS_WAIT: begin
               tmr_nxt = tmr_r + TW'(1);
               // strap sampled at the end of its conversion time
               if (tmr_r == TW'(R2D_CYC - 1)) begin
                  adj_nxt = (strapMv(r2dCode) == '0);
                  rsv_nxt = (r2dCode == 4'ha);
                  ref_nxt = adj_nxt ? `BSS_ADJ_REF_MV
                                    : strapMv(r2dCode);
               end
               if (tmr_r == TW'(WAIT_CYC - 1)) begin
                  st_nxt = BSS_SOFT;
               end
            end
            BSS_SOFT: begin
               if (ramp) begin
                  st_nxt = BSS_RUN;
               end
            end
            BSS_RUN: begin
               st_nxt = BSS_RUN;
            end
         endcase
      end
      // source only during the conversion part of the start wait
      src_nxt = (st_nxt == BSS_WAIT) &&
                (tmr_nxt < TW'(R2D_CYC));
      sw_nxt  = (st_nxt == BSS_SOFT) || (st_nxt == BSS_RUN);
      ss_nxt  = (st_nxt == BSS_SOFT);
      dis_nxt = (st_nxt == BSS_OFF) || (st_nxt == BSS_LOCK) ||
                (st_nxt == BSS_HOT);
      // strap pin becomes a mode input only once running
      ffm_nxt = (st_nxt == BSS_RUN) && (lvl || ctrlFfm_r);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r  <= BSS_OFF;
         tmr_r <= '0;
         adj_r <= 1'b1;
         rsv_r <= 1'b0;
         ref_r <= `BSS_ADJ_REF_MV;
         src_r <= 1'b0;
         sw_r  <= 1'b0;
         ss_r  <= 1'b0;
         dis_r <= 1'b1;
         ffm_r <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         tmr_r <= tmr_nxt;
         adj_r <= adj_nxt;
         rsv_r <= rsv_nxt;
         ref_r <= ref_nxt;
         src_r <= src_nxt;
         sw_r  <= sw_nxt;
         ss_r  <= ss_nxt;
         dis_r <= dis_nxt;
         ffm_r <= ffm_nxt;
      end
   end

   // output-ok: pull low unless running in window, through the filter
   logic pullLow;
   bss_deglitch #(
      .CYC     (PG_CYC),
      .RST_VAL (1'b1)
   ) u_okFilter (
      .clk    (clk),
      .rst    (rst),
      .lvlIn  (!((st_r == BSS_RUN) && win)),
      .lvlOut (pullLow)
   );

   // AXI4-Lite slave: address and data latched apart, answered together
   logic [AW-1:0] awA_r, awA_nxt, arA;
   logic          awH_r, awH_nxt, wH_r, wH_nxt;
   logic [31:0]   wD_r, wD_nxt, rD_r, rD_nxt;
   logic          wS_r, wS_nxt;
   logic          bv_r, bv_nxt, rv_r, rv_nxt;
   logic [1:0]    br_r, br_nxt, rr_r, rr_nxt;
   logic          awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
   logic          wrEn, hit;

   assign arA  = s_axi_araddr;
   assign wrEn = awH_r && wH_r && !bv_r && wS_r;

   always_comb begin
      awA_nxt = awA_r;
      awH_nxt = awH_r;
      wD_nxt  = wD_r;
      wS_nxt  = wS_r;
      wH_nxt  = wH_r;
      bv_nxt  = bv_r;
      br_nxt  = br_r;
      rv_nxt  = rv_r;
      rr_nxt  = rr_r;
      rD_nxt  = rD_r;
      hit     = 1'b0;
      if (s_axi_awvalid && awr_r) begin
         awA_nxt = s_axi_awaddr;
         awH_nxt = 1'b1;
      end
      if (s_axi_wvalid && wr_r) begin
         wD_nxt = s_axi_wdata;
         wS_nxt = s_axi_wstrb[0];                     // one byte lane used
         wH_nxt = 1'b1;
      end
      if (bv_r && s_axi_bready) begin
         bv_nxt = 1'b0;
      end
      // both halves present: commit and answer
      if (awH_r && wH_r && !bv_r) begin
         hit    = (awA_r[7:0] == `BSS_CTRL_ADDR) ||
                  (awA_r[7:0] == `BSS_STAT_ADDR) ||
                  (awA_r[7:0] == `BSS_LIVE_ADDR);
         bv_nxt  = 1'b1;
         br_nxt  = hit ? `BSS_RESP_OKAY : `BSS_RESP_SLVERR;
         awH_nxt = 1'b0;
         wH_nxt  = 1'b0;
      end
      if (rv_r && s_axi_rready) begin
         rv_nxt = 1'b0;
      end
      if (s_axi_arvalid && arr_r) begin
         rv_nxt = 1'b1;
         rr_nxt = `BSS_RESP_OKAY;
         unique case (arA[7:0])
            `BSS_CTRL_ADDR: rD_nxt = {31'h0, ctrlFfm_r};
            `BSS_STAT_ADDR: rD_nxt = {28'h0, stat_r};
            `BSS_LIVE_ADDR: rD_nxt = {11'h0, ref_r, rsv_r, adj_r, ffm_r,
                                       dis_r, st_r};
            default: begin
               rD_nxt = 32'h0;
               rr_nxt = `BSS_RESP_SLVERR;
            end
         endcase
      end
      awr_nxt = !awH_nxt && !bv_nxt;
      wr_nxt  = !wH_nxt && !bv_nxt;
      arr_nxt = !rv_nxt;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awA_r <= '0;
         awH_r <= 1'b0;
         wD_r  <= 32'h0;
         wS_r  <= 1'b0;
         wH_r  <= 1'b0;
         bv_r  <= 1'b0;
         br_r  <= `BSS_RESP_OKAY;
         rv_r  <= 1'b0;
         rr_r  <= `BSS_RESP_OKAY;
         rD_r  <= 32'h0;
         awr_r <= 1'b0;
         wr_r  <= 1'b0;
         arr_r <= 1'b0;
      end else begin
         awA_r <= awA_nxt;
         awH_r <= awH_nxt;
         wD_r  <= wD_nxt;
         wS_r  <= wS_nxt;
         wH_r  <= wH_nxt;
         bv_r  <= bv_nxt;
         br_r  <= br_nxt;
         rv_r  <= rv_nxt;
         rr_r  <= rr_nxt;
         rD_r  <= rD_nxt;
         awr_r <= awr_nxt;
         wr_r  <= wr_nxt;
         arr_r <= arr_nxt;
      end
   end

   // control and sticky status; brown-out and turn-off wipe them
   logic                 onPrev_r, onPrev_nxt, regWipe;
   logic                 ctrlFfm_nxt;
   logic [`BSS_ST_W-1:0] stat_nxt, stSet, stClr;
   assign regWipe = por || (onPrev_r && !on);
   always_comb begin
      onPrev_nxt  = on;
      ctrlFfm_nxt = ctrlFfm_r;
      stSet = '0;
      stSet[`BSS_ST_LOCK_BIT] = input_undervoltage_lockout;
      stSet[`BSS_ST_WARN_BIT] = warm;
      stSet[`BSS_ST_HOT_BIT]  = hot;
      stSet[`BSS_ST_RSVD_BIT] = rsv_r;
      stClr = '0;
      if (wrEn && awA_r[7:0] == `BSS_CTRL_ADDR) begin
         ctrlFfm_nxt = wD_r[`BSS_CTRL_FFM_BIT];
      end
      if (wrEn && awA_r[7:0] == `BSS_STAT_ADDR) begin
         stClr = wD_r[`BSS_ST_W-1:0];                  // write one to clear
      end
      // a new event wins over a clear in the same cycle
      stat_nxt = (stat_r & ~stClr) | stSet;
      // thermal shutdown itself never wipes the registers
      if (regWipe) begin
         ctrlFfm_nxt = `BSS_CTRL_RST;
         stat_nxt    = `BSS_STAT_RST;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         onPrev_r  <= 1'b0;
         ctrlFfm_r <= `BSS_CTRL_RST;
         stat_r    <= `BSS_STAT_RST;
      end else begin
         onPrev_r  <= onPrev_nxt;
         ctrlFfm_r <= ctrlFfm_nxt;
         stat_r    <= stat_nxt;
      end
   end

   // every output straight from a flip-flop, except outOkOut tied to 0
   assign r2dSourceOn   = src_r;
   assign switchEnable  = sw_r;
   assign softStartReq  = ss_r;
   assign dischargeOn   = dis_r;
   assign outOkOut      = 1'b0;                        // open drain: only low
   assign outOkOe       = pullLow;
   assign adjustMode    = adj_r;
   assign refMv         = ref_r;
   assign fixedFreqMode = ffm_r;
   assign stateOut      = st_r;
   assign s_axi_awready = awr_r;
   assign s_axi_wready  = wr_r;
   assign s_axi_bresp   = br_r;
   assign s_axi_bvalid  = bv_r;
   assign s_axi_arready = arr_r;
   assign s_axi_rdata   = rD_r;
   assign s_axi_rresp   = rr_r;
   assign s_axi_rvalid  = rv_r;

endmodule : bss_top

/* verif/bss_chk_sva.sv */
// checker for the sequencer: state path, discharge, output-ok, strap timing
// assumes binding into bss_top; one clock, async active-high reset
module bss_chk #(
   parameter int PG_CYC   = 8,
   parameter int WAIT_CYC = 40,
   parameter int R2D_CYC  = 10
) (
   input logic                clk,           // clock
   input logic                rst,           // reset
   input bss_pkg::bss_state_e stateOut,      // state
   input logic                switchEnable,  // switching allowed
   input logic                dischargeOn,   // discharge path
   input logic                outOkOe,       // output-ok pulled low
   input logic                r2dSourceOn,   // strap source
   input logic                adjustMode,    // adjustable target
   input logic [10:0]         refMv,         // reference
   input logic                fixedFreqMode  // forced fixed frequency
);
   import bss_pkg::*;
   logic [15:0] runCnt_r, runCnt_nxt, idleCnt_r, idleCnt_nxt;
   logic [15:0] waitCnt_r, waitCnt_nxt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // spans of run, non-run and wait, in cycles
   always_comb begin
      runCnt_nxt  = (stateOut == BSS_RUN) ? runCnt_r + 16'h1 : 16'h0;
      idleCnt_nxt = (stateOut != BSS_RUN) ? idleCnt_r + 16'h1 : 16'h0;
      waitCnt_nxt = (stateOut == BSS_WAIT) ? waitCnt_r + 16'h1 : 16'h0;
   end
   // counters restart with every reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         runCnt_r  <= 16'h0;
         idleCnt_r <= 16'h0;
         waitCnt_r <= 16'h0;
      end else begin
         runCnt_r  <= runCnt_nxt;
         idleCnt_r <= idleCnt_nxt;
         waitCnt_r <= waitCnt_nxt;
      end
   end
   property p_lock; stateOut == BSS_LOCK [*2] |-> !switchEnable && dischargeOn; endproperty
   a_lock: assert property (p_lock) else $error("lockout still switching");
   property p_hot; stateOut == BSS_HOT [*2] |-> !switchEnable && dischargeOn; endproperty
   a_hot: assert property (p_hot) else $error("overheat still switching");
   property p_off; stateOut == BSS_OFF [*2] |-> !switchEnable && dischargeOn; endproperty
   a_off: assert property (p_off) else $error("off still switching");
   property p_pgLow; idleCnt_r > PG_CYC + 1 |-> outOkOe; endproperty
   a_pgLow: assert property (p_pgLow) else $error("output-ok released");
   property p_pgRel; $fell(outOkOe) |-> runCnt_r >= PG_CYC; endproperty
   a_pgRel: assert property (p_pgRel) else $error("output-ok too early");
   property p_wait; stateOut == BSS_SOFT && $past(stateOut) == BSS_WAIT |-> waitCnt_r >= WAIT_CYC - 1; endproperty
   a_wait: assert property (p_wait) else $error("start wait too short");
   property p_run; stateOut == BSS_RUN |-> $past(stateOut) inside {BSS_SOFT, BSS_RUN}; endproperty
   a_run: assert property (p_run) else $error("run without soft-start");
   property p_src; r2dSourceOn |-> waitCnt_r <= R2D_CYC; endproperty
   a_src: assert property (p_src) else $error("strap source left on");
   property p_ffm; fixedFreqMode |-> stateOut == BSS_RUN || $past(stateOut) == BSS_RUN; endproperty
   a_ffm: assert property (p_ffm) else $error("fixed frequency off run");
   property p_adj; adjustMode |-> refMv == 11'h258; endproperty
   a_adj: assert property (p_adj) else $error("adjustable reference wrong");
endmodule : bss_chk

bind bss_top bss_chk #(.PG_CYC(PG_CYC), .WAIT_CYC(WAIT_CYC), .R2D_CYC(R2D_CYC))
   i_chk (.clk, .rst, .stateOut, .switchEnable, .dischargeOn, .outOkOe,
   .r2dSourceOn, .adjustMode, .refMv, .fixedFreqMode);

/* verif/bss_env_model.sv */
// far side: ramp, output window, strap resistor and output-ok pull-up
// assumes the sequencer outputs on the same clock
module bss_env_model (
   input  logic       clk,          // clock
   input  logic       slow,         // slow ramp
   input  logic       winOk,        // output would sit in window
   input  logic [3:0] strap,        // strap code fitted
   input  logic       switchEnable, // power stage active
   input  logic       softStartReq, // ramp requested
   input  logic       r2dSourceOn,  // strap source on
   input  logic       outOkOut,     // open-drain data
   input  logic       outOkOe,      // open-drain enable
   output logic       rampDone,     // ramp finished
   output logic       outInWindow,  // window comparator
   output logic       pgLine,       // output-ok wire
   output logic [3:0] r2dCode       // strap reading
);
   logic [4:0] rampCnt = 5'h0;
   // ramp ends some cycles after the stage starts
   always @(posedge clk) begin
      if (!(switchEnable || softStartReq))
         rampCnt <= 5'h0;
      else if (rampCnt != 5'h1f)
         rampCnt <= rampCnt + 5'h1;
   end
   assign rampDone    = rampCnt > (slow ? 5'h14 : 5'h01);
   // reading is junk unless the source drives the resistor
   assign r2dCode     = r2dSourceOn ? strap : ~strap;
   assign outInWindow = rampDone && winOk && switchEnable;
   assign pgLine      = outOkOe ? outOkOut : 1'b1;  // pull-up
endmodule : bss_env_model

/* verif/bss_top_tb_top.sv */
// self-checking bench: strap codes, faults, registers over AXI4-Lite
// assumes shortened timing parameters and the far-side model
module bss_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bss_pkg::*;
   localparam logic [7:0] CTRL = 8'h00, STAT = 8'h04, LIVE = 8'h08;
   localparam logic [10:0] REFS [16] = '{11'h258, 11'h190, 11'h1c2,
      11'h1f4, 11'h258, 11'h2bc, 11'h320, 11'h352, 11'h384, 11'h3e8,
      11'h258, 11'h4b0, 11'h546, 11'h5dc, 11'h640, 11'h258};
   logic clk, rst, turnOnPin, vinLockout, vinBelowPor, overheatShut;
   logic overheatWarn, outInWindow, levelSelIn, rampDone, slow, winOk;
   logic r2dSourceOn, switchEnable, softStartReq, dischargeOn, outOkOut;
   logic outOkOe, adjustMode, fixedFreqMode, pgLine;
   logic [3:0]  r2dCode, strap;
   logic [10:0] refMv;
   bss_state_e  stateOut;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, mQ[$];
   logic [1:0]  s_axi_bresp, s_axi_rresp, bQ[$];
   logic [33:0] rQ[$];
   int fail_count, checks, seed;

   bss_top #(.PG_CYC(8), .WAIT_CYC(40), .R2D_CYC(10)) i_dut (
      .clk, .rst, .turnOnPin, .vinLockout, .vinBelowPor, .overheatShut,
      .overheatWarn, .outInWindow, .levelSelIn, .rampDone, .r2dCode,
      .r2dSourceOn, .switchEnable, .softStartReq, .dischargeOn, .outOkOut,
      .outOkOe, .adjustMode, .refMv, .fixedFreqMode, .stateOut,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   bss_env_model i_env (.clk, .slow, .winOk, .strap, .switchEnable,
      .softStartReq, .r2dSourceOn, .outOkOut, .outOkOe, .rampDone,
      .outInWindow, .pgLine, .r2dCode);

   // 250 MHz
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic cmp(input string n, input logic [33:0] e, g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic complete_run();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // write; valids held until taken, bready until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      bQ.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (s_axi_bvalid !== 1'b1) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   // read; expectation under mask goes to the queue
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] r = 2'h0);
      rQ.push_back({r, e & m});
      mQ.push_back(m);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (s_axi_rvalid !== 1'b1) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   // extra cycles cover input sync and the output-ok filter
   task automatic waitSt(input bss_state_e s);
      while (stateOut !== s) @(posedge clk);
      repeat (12) @(posedge clk);
   endtask : waitSt

   function automatic logic [31:0] live(logic [5:0] s, logic d, f, a, v,
                                        logic [10:0] m);
      return {11'h0, m, v, a, f, d, s};
   endfunction : live

   // response watcher: oldest note against each handshake
   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready)
         cmp("bresp", {32'h0, bQ.pop_front()}, {32'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready)
         cmp("rdata", rQ.pop_front(), {s_axi_rresp, s_axi_rdata & mQ.pop_front()});
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   initial begin
      seed = 37097;
      {rst, turnOnPin, vinLockout, vinBelowPor} = 4'hc;
      {overheatShut, overheatWarn, levelSelIn, slow, winOk} = 5'h01;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, strap} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      // every strap code, ramp speed at random
      for (int c = 0; c < 16; c++) begin
         strap     <= c[3:0];
         slow      <= 1'($random(seed));
         turnOnPin <= 1'b1;
         waitSt(BSS_RUN);
         rd(LIVE, 32'h1fffff, live(BSS_RUN, 1'b0, 1'b0, c inside {0, 10, 15}, c == 10, REFS[c]));
         cmp("pgLine", 34'h1, {33'h0, pgLine});
         turnOnPin <= 1'b0;
         waitSt(BSS_OFF);
         rd(LIVE, 32'h7f, live(BSS_OFF, 1'b1, 1'b0, 1'b0, 1'b0, 11'h0));
         cmp("pgLine", 34'h0, {33'h0, pgLine});
      end
      strap     <= 4'h9;
      turnOnPin <= 1'b1;
      waitSt(BSS_RUN);
      wr(CTRL, 32'($random(seed)) | 32'h1, 2'h0);
      rd(LIVE, 32'h80, 32'h80);
      overheatWarn <= 1'b1;
      repeat (12) @(posedge clk);
      rd(LIVE, 32'h3f, 32'h20);
      rd(STAT, 32'h2, 32'h2);
      overheatWarn <= 1'b0;
      overheatShut <= 1'b1;
      waitSt(BSS_HOT);
      rd(LIVE, 32'hff, live(BSS_HOT, 1'b1, 1'b0, 1'b0, 1'b0, 11'h0));
      overheatShut <= 1'b0;
      waitSt(BSS_RUN);
      rd(CTRL, 32'h1, 32'h1);
      rd(STAT, 32'h6, 32'h6);
      wr(STAT, 32'hf, 2'h0);
      rd(STAT, 32'hf, 32'h0);
      vinLockout <= 1'b1;
      waitSt(BSS_LOCK);
      rd(LIVE, 32'hff, live(BSS_LOCK, 1'b1, 1'b0, 1'b0, 1'b0, 11'h0));
      rd(STAT, 32'h1, 32'h1);
      vinLockout <= 1'b0;
      waitSt(BSS_RUN);
      rd(LIVE, 32'h1fffff, live(BSS_RUN, 1'b0, 1'b1, 1'b0, 1'b0, 11'h3e8));
      wr(CTRL, 32'h0, 2'h0);
      levelSelIn <= 1'b1;
      repeat (12) @(posedge clk);
      rd(LIVE, 32'h80, 32'h80);
      levelSelIn <= 1'b0;
      repeat (12) @(posedge clk);
      rd(LIVE, 32'h80, 32'h0);
      // output leaves window: sync plus filter before the pin goes low
      winOk <= 1'b0;
      repeat (6) @(posedge clk);
      cmp("pgLine", 34'h1, {33'h0, pgLine});
      repeat (10) @(posedge clk);
      cmp("pgLine", 34'h0, {33'h0, pgLine});
      winOk <= 1'b1;
      repeat (16) @(posedge clk);
      wr(CTRL, 32'h1, 2'h0);
      turnOnPin <= 1'b0;
      waitSt(BSS_OFF);
      rd(CTRL, 32'h1, 32'h0);
      turnOnPin <= 1'b1;
      waitSt(BSS_RUN);
      wr(CTRL, 32'h1, 2'h0);
      vinBelowPor <= 1'b1;
      waitSt(BSS_OFF);
      rd(CTRL, 32'h1, 32'h0);
      rd(8'h0c, 32'h0, 32'h0, 2'h2);
      wr(8'h0c, 32'h1, 2'h2);
      complete_run();
   end
endmodule : bss_top_tb_top
